// ### shared/elw_pkg.sv
package elw_pkg;

    // Bus widths of the register port, and the number of lines.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int LINES  = 16;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL       = 8'h24;
    localparam logic [7:0] OFS_MASK_HIGH  = 8'h28;
    localparam logic [7:0] OFS_MASK_LOW   = 8'h2C;
    localparam logic [7:0] OFS_EDGE_LOW   = 8'h30;
    localparam logic [7:0] OFS_EDGE_HIGH  = 8'h34;
    localparam logic [7:0] OFS_PEND_LOW   = 8'h38;
    localparam logic [7:0] OFS_PEND_HIGH  = 8'h3C;
    localparam logic [7:0] OFS_STATUS     = 8'h40;

    // Field positions inside the control register.
    localparam int CTRL_WAKE_SEL_BIT   = 0;
    localparam int CTRL_GLOBAL_EN_BIT  = 1;
    localparam int CTRL_STOP_BIT       = 2;

    // Field positions inside the status register.
    localparam int STAT_EXIT_FLAG_BIT  = 0;
    localparam int STAT_IN_STOP_BIT    = 1;

    // Fixed line assignments.
    localparam int LINE_SOFTWARE = 0;
    localparam int LINE_USB      = 1;
    localparam int LINE_STANDBY  = 15;

    // Values after reset.
    localparam logic [15:0] RESET_MASK  = 16'h0000;
    localparam logic [15:0] RESET_EDGE  = 16'h0000;
    localparam logic [15:0] RESET_PEND  = 16'h0000;
    localparam logic [7:0]  RESET_RDATA = 8'h00;

    // Stop sequence states, Gray coded along idle, one, one-zero, stopped.
    typedef enum logic [1:0] {
        ELW_SEQ_IDLE    = 2'h0,
        ELW_SEQ_ONE     = 2'h1,
        ELW_SEQ_ONEZERO = 2'h3,
        ELW_SEQ_STOPPED = 2'h2
    } elw_seq_type;

    // One register port access.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } elw_bus_type;

    // Whole state of the line unit.
    typedef struct packed {
        logic [LINES-1:0]  mask;
        logic [LINES-1:0]  edge_sel;
        logic [LINES-1:0]  pend;
        logic              global_en;
        logic              wake_sel;
        elw_seq_type       seq;
        logic              exit_flag;
        logic              irq;
        logic [DATA_W-1:0] rdata;
    } elw_state_type;

    // Whole state of the edge detector.
    typedef struct packed {
        logic [LINES-1:0] prev;
        logic             armed;
    } elw_edge_state_type;

endpackage

// ### rtl/elw_edge_detect.sv
`timescale 1ns/1ps

module elw_edge_detect #(
    parameter int WIDTH = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] line_level,
    input  wire logic [WIDTH-1:0] rise_sel,
    output logic      [WIDTH-1:0] hit
);

    elw_pkg::elw_edge_state_type state_reg;
    elw_pkg::elw_edge_state_type state_next;

    // Edges are ignored until one sample is held, so a line already high at reset
    // with a rising trigger does not fire a false edge.
    always_comb begin
        state_next.prev  = line_level;
        state_next.armed = 1'b1;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_reg.prev  <= '0;
            state_reg.armed <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Each line compares its new level with the last one and keeps only the chosen edge.
    generate
        for (genvar i = 0; i < WIDTH; i++) begin : g_line
            always_comb begin
                if (rise_sel[i]) begin
                    hit[i] = state_reg.armed & line_level[i] & ~state_reg.prev[i];
                end else begin
                    hit[i] = state_reg.armed & ~line_level[i] & state_reg.prev[i];
                end
            end
        end
    endgenerate

endmodule

// ### rtl/elw_line_unit.sv
// Summary of operation
// - Sixteen lines: software, USB resume, fourteen pins.
// - All lines merge onto one request output.
// - Masked lines give no interrupt, no wake.
// - Per-line choice of rising or falling edge.
// - Wake select low: lines only interrupt.
// - Wake select high: unmasked pending lines wake.
// - Requests pass only with global enable set.
// - Stop refused when every line is masked.
// - Stop refused while unmasked pending bit set.
// - Stop needs writes one, zero, one.
// - Other accesses between sequence writes allowed.
// - Two zero writes return sequence to idle.
// - Acknowledge during sequence cancels, both flags zero.
// - Correct sequence stops; wake exits, flag one.
// - Partial pending clear gives fresh request edge.
// - All pending cleared: request stays low.
// - Only the standby line leaves standby.
// - Line zero is set only by software.
// - Interrupt and wake outputs are independent.
// - Wake in stop clears stop bit.
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps

module elw_line_unit #(
    parameter int PIN_COUNT = 14
) (
    input  wire logic                       ref_clk,
    input  wire logic                       reset,
    input  wire logic [7:0]                 reg_addr,
    input  wire logic [7:0]                 reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [7:0]                 reg_rdata,
    input  wire logic [PIN_COUNT-1:0]       port_lines,
    input  wire logic                       usb_end_suspend,
    input  wire logic                       irq_ack,
    input  wire logic                       standby_active,
    output logic                            line_unit_irq_channel,
    output logic                            wake_event,
    output logic                            stop_request,
    output logic                            standby_wake
);

    elw_pkg::elw_state_type state_reg;
    elw_pkg::elw_state_type state_next;
    elw_pkg::elw_bus_type   bus;

    logic [15:0] line_level;
    logic [15:0] edge_hit;
    logic [15:0] armed_pend;
    logic        any_armed;
    logic        stop_allowed;
    logic        wake_now;
    logic        pend_cleared;

    // Register address decode, used both by the read path and the write path.
    function automatic logic hit_addr(input logic [7:0] addr, input logic [7:0] ofs);
        hit_addr = (addr == ofs);
    endfunction

    // Read value of one register; unmapped offsets and reserved bits read zero.
    function automatic logic [7:0] read_value(input logic [7:0] addr,
                                              input elw_pkg::elw_state_type s);
        logic [7:0] v;
        v = 8'h00;
        if (hit_addr(addr, elw_pkg::OFS_CTRL)) begin
            v[elw_pkg::CTRL_WAKE_SEL_BIT]  = s.wake_sel;
            v[elw_pkg::CTRL_GLOBAL_EN_BIT] = s.global_en;
            v[elw_pkg::CTRL_STOP_BIT]      = (s.seq == elw_pkg::ELW_SEQ_ONE) ||
                                             (s.seq == elw_pkg::ELW_SEQ_STOPPED);
        end else if (hit_addr(addr, elw_pkg::OFS_MASK_LOW)) begin
            v = s.mask[7:0];
        end else if (hit_addr(addr, elw_pkg::OFS_MASK_HIGH)) begin
            v = s.mask[15:8];
        end else if (hit_addr(addr, elw_pkg::OFS_EDGE_LOW)) begin
            v = s.edge_sel[7:0];
        end else if (hit_addr(addr, elw_pkg::OFS_EDGE_HIGH)) begin
            v = s.edge_sel[15:8];
        end else if (hit_addr(addr, elw_pkg::OFS_PEND_LOW)) begin
            v = s.pend[7:0];
        end else if (hit_addr(addr, elw_pkg::OFS_PEND_HIGH)) begin
            v = s.pend[15:8];
        end else if (hit_addr(addr, elw_pkg::OFS_STATUS)) begin
            v[elw_pkg::STAT_EXIT_FLAG_BIT] = s.exit_flag;
            v[elw_pkg::STAT_IN_STOP_BIT]   = (s.seq == elw_pkg::ELW_SEQ_STOPPED);
        end
        read_value = v;
    endfunction

    // Bundle the register port so the processes below see one access.
    assign bus.addr  = reg_addr;
    assign bus.wdata = reg_wdata;
    assign bus.wr    = reg_wr;
    assign bus.rd    = reg_rd;

    // Line zero has no hardware source and stays low here; line one is the
    // USB resume event and the rest are the port pins.
    assign line_level[elw_pkg::LINE_SOFTWARE] = 1'b0;
    assign line_level[elw_pkg::LINE_USB]      = usb_end_suspend;
    assign line_level[15:2]                   = port_lines;

    elw_edge_detect #(
        .WIDTH(16)
    ) u_edge (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .line_level(line_level),
        .rise_sel  (state_reg.edge_sel),
        .hit       (edge_hit)
    );

    // Only unmasked pending lines count toward requests, wake and stop checks.
    assign armed_pend   = state_reg.pend & state_reg.mask;
    assign any_armed    = |armed_pend;
    assign stop_allowed = state_reg.wake_sel && (|state_reg.mask) && !any_armed;
    assign wake_now     = state_reg.wake_sel && any_armed;

    // A pending write that drops at least one set bit. The request is pulled low
    // for one cycle so the controller sees a new rising edge if others remain.
    always_comb begin
        pend_cleared = 1'b0;
        if (bus.wr && hit_addr(bus.addr, elw_pkg::OFS_PEND_LOW)) begin
            pend_cleared = |(state_reg.pend[7:0] & ~bus.wdata);
        end else if (bus.wr && hit_addr(bus.addr, elw_pkg::OFS_PEND_HIGH)) begin
            pend_cleared = |(state_reg.pend[15:8] & ~bus.wdata);
        end
    end

    // Next state of the whole unit.
    always_comb begin
        state_next = state_reg;

        // Mask and edge registers take the written byte as it stands; control keeps only its wake select and global enable bits.
        if (bus.wr && hit_addr(bus.addr, elw_pkg::OFS_MASK_LOW)) begin
            state_next.mask[7:0] = bus.wdata;
        end
        if (bus.wr && hit_addr(bus.addr, elw_pkg::OFS_MASK_HIGH)) begin
            state_next.mask[15:8] = bus.wdata;
        end
        if (bus.wr && hit_addr(bus.addr, elw_pkg::OFS_EDGE_LOW)) begin
            state_next.edge_sel[7:0] = bus.wdata;
        end
        if (bus.wr && hit_addr(bus.addr, elw_pkg::OFS_EDGE_HIGH)) begin
            state_next.edge_sel[15:8] = bus.wdata;
        end
        if (bus.wr && hit_addr(bus.addr, elw_pkg::OFS_CTRL)) begin
            state_next.wake_sel  = bus.wdata[elw_pkg::CTRL_WAKE_SEL_BIT];
            state_next.global_en = bus.wdata[elw_pkg::CTRL_GLOBAL_EN_BIT];
        end

        // Pending bits: a written zero clears, a written one keeps the bit,
        // except on line zero where a one sets it. A fresh edge in the same
        // cycle is ORed in last, so a set always beats a clear.
        if (bus.wr && hit_addr(bus.addr, elw_pkg::OFS_PEND_LOW)) begin
            state_next.pend[7:0] = state_reg.pend[7:0] & bus.wdata;
            state_next.pend[elw_pkg::LINE_SOFTWARE] = bus.wdata[elw_pkg::LINE_SOFTWARE];
        end
        if (bus.wr && hit_addr(bus.addr, elw_pkg::OFS_PEND_HIGH)) begin
            state_next.pend[15:8] = state_reg.pend[15:8] & bus.wdata;
        end
        state_next.pend = state_next.pend | edge_hit;

        // Exit flag: software clears it by writing one; the hardware set wins.
        if (bus.wr && hit_addr(bus.addr, elw_pkg::OFS_STATUS) &&
            bus.wdata[elw_pkg::STAT_EXIT_FLAG_BIT]) begin
            state_next.exit_flag = 1'b0;
        end

        // Stop sequence recogniser. Only control register writes, an acknowledge or a wake move it,
        // so any other register access in between is harmless.
        case (state_reg.seq)
            elw_pkg::ELW_SEQ_IDLE: begin
                if (bus.wr && hit_addr(bus.addr, elw_pkg::OFS_CTRL) &&
                    bus.wdata[elw_pkg::CTRL_STOP_BIT]) begin
                    state_next.seq = elw_pkg::ELW_SEQ_ONE;
                end
            end
            elw_pkg::ELW_SEQ_ONE: begin
                if (irq_ack) begin
                    state_next.seq       = elw_pkg::ELW_SEQ_IDLE;
                    state_next.exit_flag = 1'b0;
                end else if (bus.wr && hit_addr(bus.addr, elw_pkg::OFS_CTRL) &&
                             !bus.wdata[elw_pkg::CTRL_STOP_BIT]) begin
                    state_next.seq = elw_pkg::ELW_SEQ_ONEZERO;
                end
            end
            elw_pkg::ELW_SEQ_ONEZERO: begin
                if (irq_ack) begin
                    state_next.seq       = elw_pkg::ELW_SEQ_IDLE;
                    state_next.exit_flag = 1'b0;
                end else if (bus.wr && hit_addr(bus.addr, elw_pkg::OFS_CTRL)) begin
                    if (!bus.wdata[elw_pkg::CTRL_STOP_BIT]) begin
                        state_next.seq = elw_pkg::ELW_SEQ_IDLE;
                    end else if (stop_allowed) begin
                        state_next.seq = elw_pkg::ELW_SEQ_STOPPED;
                    end else begin
                        state_next.seq = elw_pkg::ELW_SEQ_IDLE;
                    end
                end
            end
            elw_pkg::ELW_SEQ_STOPPED: begin
                // Stop-bit writes are ignored here; the core is frozen anyway.
                if (wake_now) begin
                    state_next.seq       = elw_pkg::ELW_SEQ_IDLE;
                    state_next.exit_flag = 1'b1;
                end
            end
            default: begin
                state_next.seq = elw_pkg::ELW_SEQ_IDLE;
            end
        endcase

        // Edge-style request: high while enabled unmasked lines pend, with a
        // one-cycle gap after each partial clear.
        state_next.irq = state_reg.global_en && any_armed && !pend_cleared;

        // Read data stand only in the cycle after the read strobe.
        state_next.rdata = bus.rd ? read_value(bus.addr, state_reg) : elw_pkg::RESET_RDATA;
    end

    // Every bit of state is registered here.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_reg.mask      <= elw_pkg::RESET_MASK;
            state_reg.edge_sel  <= elw_pkg::RESET_EDGE;
            state_reg.pend      <= elw_pkg::RESET_PEND;
            state_reg.global_en <= 1'b0;
            state_reg.wake_sel  <= 1'b0;
            state_reg.seq       <= elw_pkg::ELW_SEQ_IDLE;
            state_reg.exit_flag <= 1'b0;
            state_reg.irq       <= 1'b0;
            state_reg.rdata     <= elw_pkg::RESET_RDATA;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs. The wake output ignores the global enable so the two paths
    // stay independent.
    assign reg_rdata             = state_reg.rdata;
    assign line_unit_irq_channel = state_reg.irq;
    assign wake_event            = wake_now;
    assign stop_request          = (state_reg.seq == elw_pkg::ELW_SEQ_STOPPED);
    // Standby is left only through the dedicated line, and only when it is armed.
    assign standby_wake          = standby_active && state_reg.wake_sel &&
                                   armed_pend[elw_pkg::LINE_STANDBY];

endmodule

// ### test/elw_ctrl_model.sv
`timescale 1ns/1ps

// Far-side interrupt controller channel: it pends on a rising request edge only.
module elw_ctrl_model (
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic irq_in,
    input  wire logic ack_cmd,
    output logic      irq_ack,
    output logic      chan_pend
);
    logic irq_last;

    // A request that merely stays high never pends the channel again, so a missing re-edge shows up here.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq_last  <= 1'b0;
            chan_pend <= 1'b0;
        end else begin
            irq_last  <= irq_in;
            chan_pend <= (irq_in && !irq_last) || (chan_pend && !irq_ack);
        end
    end

    // The core acknowledges only a pending channel, on the bench's command.
    assign irq_ack = ack_cmd && chan_pend;
endmodule

// ### test/elw_line_unit_properties.sv
`timescale 1ns/1ps

module elw_line_unit_props (
    input wire logic       ref_clk,
    input wire logic       reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       irq_ack,
    input wire logic       standby_active,
    input wire logic       line_unit_irq_channel,
    input wire logic       wake_event,
    input wire logic       stop_request,
    input wire logic       standby_wake
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    // Read data may only appear right after a read of a word-aligned offset.
    a_rdata_quiet: assert property ((!$past(reg_rd) || $past(reg_addr[1:0]) != 2'h0) |-> reg_rdata == 8'h00)
        else $error("read data outside a valid read slot");
    a_entry_cause: assert property ($rose(stop_request) |->
        $past(reg_wr) && $past(reg_addr) == elw_pkg::OFS_CTRL && $past(reg_wdata[2]))
        else $error("stop entered without a stop bit write of one");
    a_entry_clean: assert property ($rose(stop_request) |-> !$past(wake_event))
        else $error("stop entered with an unmasked wake pending");
    a_exit_wake: assert property (stop_request && wake_event |=> !stop_request)
        else $error("stop not left on a wake event");
    a_stop_holds: assert property (stop_request && !wake_event |=> stop_request)
        else $error("stop left without a wake event");
    a_ack_cancels: assert property (irq_ack && !stop_request && !reg_wr |=> !stop_request)
        else $error("stop entered after an acknowledge");
    a_standby_gate: assert property (standby_wake |-> standby_active && wake_event)
        else $error("standby wake without standby and wake event");
    a_irq_fall: assert property ($fell(line_unit_irq_channel) |-> $past(reg_wr) || $past(reg_wr, 2))
        else $error("request fell without a register write");

    // Main scenarios reached.
    c_stop_in: cover property ($rose(stop_request));
    c_stop_out: cover property ($fell(stop_request));
    c_standby: cover property ($rose(standby_wake));
endmodule

bind elw_line_unit elw_line_unit_props i_elw_line_unit_props (
    .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_ack(irq_ack),
    .standby_active(standby_active), .line_unit_irq_channel(line_unit_irq_channel),
    .wake_event(wake_event), .stop_request(stop_request), .standby_wake(standby_wake));

// ### test/tb_elw_line_unit.sv
`timescale 1ns/1ps

module tb_elw_line_unit;
    localparam logic [7:0] ctl = elw_pkg::OFS_CTRL, ml = elw_pkg::OFS_MASK_LOW, mh = elw_pkg::OFS_MASK_HIGH,
        el = elw_pkg::OFS_EDGE_LOW, eh = elw_pkg::OFS_EDGE_HIGH, pl = elw_pkg::OFS_PEND_LOW,
        ph = elw_pkg::OFS_PEND_HIGH, st = elw_pkg::OFS_STATUS;
    logic        ref_clk;
    logic        reset;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic [13:0] port_lines;
    logic        usb_end_suspend;
    logic        irq_ack;
    logic        standby_active;
    logic        irq_line;
    logic        wake_event;
    logic        stop_request;
    logic        standby_wake;
    logic        ack_cmd;
    logic        chan_pend;
    int          n_fail;
    int          compares;
    int          n_cyc;

    elw_line_unit #(.PIN_COUNT(14)) i_elw_line_unit (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_lines(port_lines),
        .usb_end_suspend(usb_end_suspend), .irq_ack(irq_ack), .standby_active(standby_active),
        .line_unit_irq_channel(irq_line), .wake_event(wake_event), .stop_request(stop_request),
        .standby_wake(standby_wake));
    elw_ctrl_model i_elw_ctrl_model (.ref_clk(ref_clk), .reset(reset), .irq_in(irq_line), .ack_cmd(ack_cmd),
        .irq_ack(irq_ack), .chan_pend(chan_pend));

    // Free-running 100 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task print_verdict;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // A hang is cut short well beyond the few hundred cycles the tests need.
    always @(posedge ref_clk) begin
        n_cyc = n_cyc + 1;
        if (n_cyc == 5000) begin
            n_fail++;
            print_verdict();
        end
    end

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Waits are taken 1 ns past the edge so registered outputs have settled.
    task cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken there.
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask

    task ln(input logic [13:0] p, input logic u);
        @(posedge ref_clk);
        port_lines <= p;
        usb_end_suspend <= u;
        cyc(3);
    endtask

    task ack;
        @(posedge ref_clk);
        ack_cmd <= 1'b1;
        @(posedge ref_clk);
        ack_cmd <= 1'b0;
        cyc(1);
    endtask

    task seq(input logic [7:0] c);
        wr(ctl, c | 8'h04);
        wr(ctl, c);
        wr(ctl, c | 8'h04);
        cyc(1);
    endtask

    task t_reset;
        logic [7:0] a [8];
        a = '{ctl, ml, mh, el, eh, pl, ph, st};
        wr(8'h25, 8'hFF);
        foreach (a[i]) rd(a[i], 8'h00);
        rd(8'h25, 8'h00);
        $display("t_reset done");
    endtask

    task t_irq;
        wr(ml, 8'h06);
        wr(el, 8'h0C);
        wr(ctl, 8'h02);
        ln(14'h0001, 1'b0);
        chk({irq_line, chan_pend}, 2'h3);
        rd(pl, 8'h04);
        ack();
        chk(chan_pend, 1'b0);
        ln(14'h0001, 1'b1);
        rd(pl, 8'h04);
        ln(14'h0001, 1'b0);
        ln(14'h0003, 1'b0);
        rd(pl, 8'h0E);
        wr(pl, 8'hFB);
        cyc(3);
        chk({irq_line, chan_pend}, 2'h3);
        wr(ph, 8'h00);
        wr(pl, 8'h00);
        ln(14'h0000, 1'b0);
        ln(14'h0002, 1'b0);
        chk(irq_line, 1'b0);
        rd(pl, 8'h08);
        wr(ml, 8'h07);
        wr(pl, 8'h01);
        cyc(3);
        chk(irq_line, 1'b1);
        wr(ctl, 8'h00);
        cyc(3);
        chk(irq_line, 1'b0);
        wr(pl, 8'h00);
        wr(ctl, 8'h02);
        $display("t_irq done");
    endtask

    task t_stop;
        seq(8'h02);
        chk(stop_request, 1'b0);
        wr(ml, 8'h00);
        seq(8'h03);
        chk(stop_request, 1'b0);
        wr(ml, 8'h05);
        wr(pl, 8'h01);
        seq(8'h03);
        chk(stop_request, 1'b0);
        wr(pl, 8'h00);
        wr(ctl, 8'h07);
        wr(ctl, 8'h03);
        wr(ctl, 8'h03);
        wr(ctl, 8'h07);
        cyc(1);
        chk(stop_request, 1'b0);
        wr(ctl, 8'h03);
        wr(ctl, 8'h03);
        rd(ctl, 8'h03);
        wr(ctl, 8'h07);
        ln(14'h0003, 1'b0);
        ack();
        rd(ctl, 8'h03);
        wr(pl, 8'h00);
        wr(ctl, 8'h03);
        wr(ctl, 8'h07);
        cyc(1);
        chk(stop_request, 1'b0);
        rd(st, 8'h00);
        rd(ctl, 8'h07);
        wr(st, 8'h01);
        wr(ctl, 8'h07);
        rd(ml, 8'h05);
        wr(ctl, 8'h03);
        wr(ctl, 8'h07);
        cyc(1);
        chk(stop_request, 1'b1);
        rd(ctl, 8'h07);
        ln(14'h0002, 1'b0);
        chk(stop_request, 1'b1);
        ln(14'h0003, 1'b0);
        chk(stop_request, 1'b0);
        rd(st, 8'h01);
        rd(ctl, 8'h03);
        rd(pl, 8'h04);
        wr(pl, 8'h00);
        wr(st, 8'h01);
        $display("t_stop done");
    endtask

    task t_standby;
        wr(mh, 8'hC0);
        wr(eh, 8'hC0);
        @(posedge ref_clk);
        standby_active <= 1'b1;
        ln(14'h1003, 1'b0);
        chk({wake_event, standby_wake}, 2'h2);
        ln(14'h3003, 1'b0);
        chk(standby_wake, 1'b1);
        wr(ctl, 8'h01);
        cyc(3);
        chk({wake_event, irq_line}, 2'h2);
        wr(ctl, 8'h02);
        cyc(3);
        chk({wake_event, irq_line}, 2'h1);
        $display("t_standby done");
    endtask

    // Main sequence: reset held for 8 cycles, then the scenarios in turn.
    initial begin
        {n_fail, compares, n_cyc} = '0;
        reset = 1'b1;
        {reg_addr, reg_wdata, reg_wr, reg_rd, ack_cmd, standby_active} = '0;
        {port_lines, usb_end_suspend} = '0;
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset();
        t_irq();
        t_stop();
        t_standby();
        print_verdict();
    end
endmodule
